// ---- core/hbd_ctrl.sv ----
// top of the h-bridge drive controller: register port, interrupt,
// warning pin input and the three bridge input pins
// assumes the bridge's warning pin has an external pull-up
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "hbd_params.svh"
module hbd_ctrl (
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	input  wire logic [`HBD_ADDR_W-1:0] regAddr,
	input  wire logic [31:0]            regWdata,
	input  wire logic                   regWr,
	input  wire logic                   regRd,
	output logic      [31:0]            regRdata,
	output logic                        irq,
	input  wire logic                   warnPin_n,
	output logic                        dirPin,
	output logic                        brakePin,
	output logic                        pwmPin
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [`HBD_CTRL_W-1:0] ctrl_q;      // control bits
	logic [7:0]             duty_q;      // duty in period counts
	logic [7:0]             period_q;    // period top
	logic [`HBD_INT_W-1:0]  intSt_q;     // sticky events
	logic [`HBD_INT_W-1:0]  intMask_q;   // event enables
	logic [31:0]            rdata_q;     // read data
	logic                   irq_q;       // interrupt level
	logic                   warnS1_q;    // sync stage one
	logic                   warnS2_q;    // sync stage two
	logic                   warnOld_q;   // last synced warning
	logic                   stop_q;      // auto stop latched
	logic                   warn;        // warning active, high
	logic                   warnRise;    // warning start event
	logic                   warnFall;    // warning end event
	logic [`HBD_INT_W-1:0]  evt;         // this cycle's events
	hbd_pin_if              pinIf ();

	// ------------------------------------------------------------
	// warning input
	// ------------------------------------------------------------
	// open-collector pin, pulled up; only read after two flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			warnS1_q  <= 1'b1;
			warnS2_q  <= 1'b1;
			warnOld_q <= 1'b0;
		end else begin
			warnS1_q  <= warnPin_n;
			warnS2_q  <= warnS1_q;
			warnOld_q <= ~warnS2_q;
		end
	end

	// active low at the pin; 145 C warning, bridge still running
	assign warn     = ~warnS2_q;
	assign warnRise = warn & ~warnOld_q;
	assign warnFall = ~warn & warnOld_q;
	assign evt      = {warnFall, warnRise};

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q    <= `HBD_CTRL_RST;
			duty_q    <= `HBD_DUTY_RST;
			period_q  <= `HBD_PERIOD_RST;
			intMask_q <= `HBD_MASK_RST;
		end else if (regWr) begin
			case (regAddr)
				`HBD_A_CTRL:    ctrl_q    <= regWdata[`HBD_CTRL_W-1:0];
				`HBD_A_DUTY:    duty_q    <= regWdata[7:0];
				`HBD_A_PERIOD:  period_q  <= regWdata[7:0];
				`HBD_A_INTMASK: intMask_q <= regWdata[`HBD_INT_W-1:0];
				default:        ;   // other addresses ignore writes here; INTST writes clear below
			endcase
		end
	end

	// ------------------------------------------------------------
	// interrupt status, write one to clear, set wins
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			intSt_q <= '0;
		end else if (regWr && regAddr == `HBD_A_INTST) begin
			intSt_q <= (intSt_q & ~regWdata[`HBD_INT_W-1:0]) | evt;
		end else begin
			intSt_q <= intSt_q | evt;
		end
	end

	// warning is the controller's interrupt
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(intSt_q & intMask_q);
		end
	end

	// ------------------------------------------------------------
	// orderly stop on warning
	// ------------------------------------------------------------
	// held until software drops the enable; device-side 170 C
	// shutdown and current retry need nothing here
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_q <= 1'b0;
		end else if (!ctrl_q[`HBD_C_EN]) begin
			stop_q <= 1'b0;
		end else if (warn && ctrl_q[`HBD_C_AUTOSTOP]) begin
			stop_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// reads, data one cycle later
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (regRd) begin
			case (regAddr)
				`HBD_A_CTRL:    rdata_q <= {26'h0, ctrl_q};
				`HBD_A_DUTY:    rdata_q <= {24'h0, duty_q};
				`HBD_A_PERIOD:  rdata_q <= {24'h0, period_q};
				`HBD_A_STATUS:  rdata_q <= {26'h0, pinIf.pins.pwm, pinIf.pins.brake,
				                            pinIf.pins.dir, pinIf.busy, stop_q, warn};
				`HBD_A_INTST:   rdata_q <= {30'h0, intSt_q};
				`HBD_A_INTMASK: rdata_q <= {30'h0, intMask_q};
				default:        rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// waveform and pin sequencing
	// ------------------------------------------------------------
	hbd_pwm_gen uGen (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ctrl    (ctrl_q),
		.duty    (duty_q),
		.period  (period_q),
		.stopReq (stop_q),
		.pinIf   (pinIf)
	);

	hbd_pin_seq uSeq (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pinIf   (pinIf)
	);

	// pins come straight from the sequencer flops; brake-high
	// reset state keeps every switch off
	assign dirPin   = pinIf.pins.dir;
	assign brakePin = pinIf.pins.brake;
	assign pwmPin   = pinIf.pins.pwm;
	assign regRdata = rdata_q;
	assign irq      = irq_q;
endmodule

// ---- core/hbd_params.svh ----
// constants for the h-bridge drive controller
// assumes ref_clk at 50 MHz and a bridge with direction, brake and pwm pins
//
// Functional notes
// - anti-phase: duty on direction, pwm high
// - sign/magnitude: sign on direction, duty on pwm
// - input transitions at least 1 us apart
// - keep 1 us between successive transitions
// - treat warning as interrupt, reduce drive
// - hold each input pulse at least 1 us
`ifndef HBD_PARAMS_SVH
`define HBD_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HBD_CLK_MHZ        50
`define HBD_SEP_NS         1000
`define HBD_SEP_CYC        ((`HBD_SEP_NS * `HBD_CLK_MHZ + 999) / 1000)
`define HBD_HOLD_NS        1000
`define HBD_HOLD_CYC       ((`HBD_HOLD_NS * `HBD_CLK_MHZ + 999) / 1000)
`define HBD_CNT_W          8

// ----------------------------------------------------------------
// register map (word addresses on the local port)
// ----------------------------------------------------------------
`define HBD_ADDR_W         4
`define HBD_A_CTRL         4'h0
`define HBD_A_DUTY         4'h1
`define HBD_A_PERIOD       4'h2
`define HBD_A_STATUS       4'h3
`define HBD_A_INTST        4'h4
`define HBD_A_INTMASK      4'h5

// ctrl fields
`define HBD_C_EN           0
`define HBD_C_MODE         1
`define HBD_C_SIGN         2
`define HBD_C_BRAKE        3
`define HBD_C_COAST        4
`define HBD_C_AUTOSTOP     5
`define HBD_CTRL_W         6
`define HBD_CTRL_RST       6'h00
`define HBD_DUTY_RST       8'h00
`define HBD_PERIOD_RST     8'hff
`define HBD_MASK_RST       2'h0

// interrupt bits
`define HBD_I_WARN         0
`define HBD_I_CLEAR        1
`define HBD_INT_W          2

`endif

// ---- core/hbd_pin_if.sv ----
// carrier between the waveform generator and the pin sequencer
// assumes a single ref_clk domain
`timescale 1ns/100ps
interface hbd_pin_if;
	hbd_pkg::hbd_pins_type want;   // target pin levels
	hbd_pkg::hbd_pins_type pins;   // levels now on the pins
	logic                  busy;   // sequencer still spacing edges
	modport gen (output want, input pins, input busy);
	modport seq (input want, output pins, output busy);
endinterface

// ---- core/hbd_pin_seq.sv ----
// pin sequencer: moves one pin at a time with guaranteed spacing
// assumes inputs are from the same clock domain
`timescale 1ns/100ps
`include "hbd_params.svh"
module hbd_pin_seq (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	hbd_pin_if.seq    pinIf
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	hbd_pkg::hbd_seq_state_type state_q;   // sequencer state
	hbd_pkg::hbd_pins_type      pins_q;    // driven pin levels
	logic [`HBD_CNT_W-1:0]      cnt_q;     // spacing counter

	// first differing pin: brake rising before direction before pwm before brake falling;
	// one change per step so no two edges ever align
	function automatic hbd_pkg::hbd_pins_type step(input hbd_pkg::hbd_pins_type cur,
	                                               input hbd_pkg::hbd_pins_type tgt);
		hbd_pkg::hbd_pins_type r;
		r = cur;
		if (cur.brake != tgt.brake && tgt.brake) r.brake = 1'b1;
		else if (cur.dir != tgt.dir) r.dir = tgt.dir;
		else if (cur.pwm != tgt.pwm) r.pwm = tgt.pwm;
		else r.brake = tgt.brake;
		return r;
	endfunction

	// ------------------------------------------------------------
	// edge spacing
	// ------------------------------------------------------------
	// one edge, then a full separation before any other
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= hbd_pkg::SEQ_IDLE;
			pins_q  <= '{dir: 1'b0, brake: 1'b1, pwm: 1'b0};
			cnt_q   <= '0;
		end else begin
			case (state_q)
				hbd_pkg::SEQ_IDLE: begin
					if (pinIf.want != pins_q) begin
						state_q <= hbd_pkg::SEQ_PIN;
					end
				end
				hbd_pkg::SEQ_PIN: begin
					pins_q  <= step(pins_q, pinIf.want);
					cnt_q   <= `HBD_CNT_W'(`HBD_SEP_CYC);
					state_q <= hbd_pkg::SEQ_HOLD;
				end
				hbd_pkg::SEQ_HOLD: begin
					// wait covers both 1 us separation and pulse width
					if (cnt_q == `HBD_CNT_W'(1)) begin
						state_q <= hbd_pkg::SEQ_GAP;
					end
					cnt_q <= cnt_q - `HBD_CNT_W'(1);
				end
				hbd_pkg::SEQ_GAP: begin
					state_q <= (pinIf.want != pins_q) ? hbd_pkg::SEQ_PIN
					                                   : hbd_pkg::SEQ_IDLE;
				end
				default: begin
					state_q <= hbd_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	assign pinIf.pins = pins_q;
	assign pinIf.busy = (state_q != hbd_pkg::SEQ_IDLE);
endmodule

// ---- core/hbd_pkg.sv ----
// types for the h-bridge drive controller
// assumes the params header is included by users
package hbd_pkg;
	// pin sequencer states, one-hot
	typedef enum logic [3:0] {
		SEQ_IDLE = 4'b0001,
		SEQ_GAP  = 4'b0010,
		SEQ_PIN  = 4'b0100,
		SEQ_HOLD = 4'b1000
	} hbd_seq_state_type;

	// requested pin levels
	typedef struct packed {
		logic dir;
		logic brake;
		logic pwm;
	} hbd_pins_type;
endpackage

// ---- core/hbd_pwm_gen.sv ----
// duty generator: makes target pin levels from mode, sign and duty
// assumes the sequencer spaces the edges it asks for
`timescale 1ns/100ps
`include "hbd_params.svh"
module hbd_pwm_gen (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic [`HBD_CTRL_W-1:0] ctrl,
	input  wire logic [7:0]            duty,
	input  wire logic [7:0]            period,
	input  wire logic                  stopReq,
	hbd_pin_if.gen                     pinIf
);
	// ------------------------------------------------------------
	// period counter
	// ------------------------------------------------------------
	logic [7:0] phase_q;   // position in pwm period
	logic       active;    // duty portion of period

	// free running; period register sets the top
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= 8'h00;
		end else if (phase_q >= period) begin
			phase_q <= 8'h00;
		end else begin
			phase_q <= phase_q + 8'h01;
		end
	end

	assign active = (phase_q < duty);

	// ------------------------------------------------------------
	// target levels
	// ------------------------------------------------------------
	// a short period limits resolution: edges closer than the
	// sequencer spacing get stretched, but a pulse over before SEQ_PIN samples want is dropped
	always_comb begin
		pinIf.want = '{dir: 1'b0, brake: 1'b1, pwm: 1'b0}; // all off
		if (!ctrl[`HBD_C_EN] || stopReq || ctrl[`HBD_C_COAST]) begin
			pinIf.want = '{dir: 1'b0, brake: 1'b1, pwm: 1'b0}; // coast
		end else if (ctrl[`HBD_C_BRAKE]) begin
			pinIf.want = '{dir: 1'b0, brake: 1'b1, pwm: 1'b1}; // short load low
		end else if (ctrl[`HBD_C_MODE]) begin
			// anti-phase: duty on direction, pwm held high
			pinIf.want = '{dir: active, brake: 1'b0, pwm: 1'b1};
		end else begin
			// sign/magnitude: zero duty means pwm stays low
			pinIf.want = '{dir: ctrl[`HBD_C_SIGN], brake: 1'b0, pwm: active};
		end
	end
endmodule

// ---- dv/hbd_bridge_model.sv ----
// behavioural bridge: pin decode, thermal flag, current cut-off
// assumes an external pull-up on the flag line
`timescale 1ns/100ps
module hbd_bridge_model (
	input  wire logic       ref_clk,
	input  wire logic       dirPin,
	input  wire logic       brakePin,
	input  wire logic       pwmPin,
	input  wire logic [7:0] tempC,
	input  wire logic       overAmp,
	output logic            warnPull,
	output logic      [3:0] sw,
	output int              shoot
);
	logic [3:0] dec;          // src1 src2 snk1 snk2
	logic       cut = 1'b0;   // sources cut by over-current
	logic [3:0] retry = 4'h0; // retry period counter
	int         shootCnt = 0; // source and sink of one side both on
	assign shoot = shootCnt;
	// truth table; no row pairs a source with its own sink
	always_comb begin
		case ({pwmPin, brakePin})
			2'b10: dec = dirPin ? 4'h9 : 4'h6;
			2'b00: dec = 4'hc;
			2'b11: dec = dirPin ? 4'hc : 4'h3;
			default: dec = 4'h0;
		endcase
	end
	// hot die drops all, a cut drops the sources only
	assign sw = (tempC >= 8'haa) ? 4'h0 : dec & {~cut, ~cut, 2'b11};
	// open collector: only ever sinks, so flags can be wired together
	assign warnPull = tempC >= 8'h91;
	// fault retried every 16 cycles while it lasts
	always_ff @(posedge ref_clk) begin
		retry <= retry + 4'h1;
		if (overAmp && (sw[3] || sw[2])) cut <= 1'b1;
		else if (retry == 4'hf) cut <= 1'b0;
		if ((sw[3] && sw[1]) || (sw[2] && sw[0])) shootCnt <= shootCnt + 1;
	end
endmodule

// ---- dv/hbd_ctrl_asserts.sv ----
// checker for the h-bridge drive controller, top ports only
// assumes one ref_clk domain and the params header on the include path
`timescale 1ns/100ps
`include "hbd_params.svh"
module hbd_ctrl_asserts (
	input wire logic                   ref_clk,
	input wire logic                   rst_n,
	input wire logic [`HBD_ADDR_W-1:0] regAddr,
	input wire logic [31:0]            regWdata,
	input wire logic                   regWr,
	input wire logic                   regRd,
	input wire logic [31:0]            regRdata,
	input wire logic                   irq,
	input wire logic                   warnPin_n,
	input wire logic                   dirPin,
	input wire logic                   brakePin,
	input wire logic                   pwmPin
);
	logic [2:0] pinsNow;   // bridge inputs as one vector
	logic [2:0] pinsOld_q; // pins one cycle ago
	logic [7:0] quiet_q;   // cycles since last pin edge
	logic [3:0] warnAge_q; // cycles since the flag moved
	logic       wrote_q;   // a write seen since reset
	logic       edgeNow;   // some pin moves now
	assign pinsNow = {dirPin, brakePin, pwmPin};
	assign edgeNow = pinsNow != pinsOld_q;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// history counters saturate so a long idle never wraps
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinsOld_q <= 3'h2;
			quiet_q   <= 8'hff;
			warnAge_q <= 4'hf;
			wrote_q   <= 1'b0;
		end else begin
			pinsOld_q <= pinsNow;
			quiet_q   <= edgeNow ? 8'h00 : quiet_q + {7'h0, quiet_q != 8'hff};
			warnAge_q <= $changed(warnPin_n) ? 4'h0 : warnAge_q + {3'h0, warnAge_q != 4'hf};
			wrote_q   <= wrote_q | regWr;
		end
	end
	a_edge_spacing: assert property (edgeNow |-> quiet_q >= 8'h31)
		else $error("pin edges closer than 1 us");
	a_single_edge: assert property ($onehot0(pinsNow ^ pinsOld_q))
		else $error("two pins moved together");
	a_dir_hold: assert property ($changed(dirPin) |=> $stable(dirPin) [*8])
		else $error("direction pulse too short");
	a_reset_coast: assert property ($rose(rst_n) |-> pinsNow == 3'h2)
		else $error("pins not coasting after reset");
	a_pins_wait_write: assert property (edgeNow |-> wrote_q)
		else $error("pins moved before any command");
	a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property ($past(regRd) && $past(regAddr) > 4'h5 |-> regRdata == 32'h0)
		else $error("unmapped read not zero");
	a_irq_cause: assert property ($rose(irq) |-> warnAge_q < 4'h8 || $past(regWr) || $past(regWr, 2))
		else $error("interrupt rose without cause");
endmodule

bind hbd_ctrl hbd_ctrl_asserts chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
	.warnPin_n(warnPin_n), .dirPin(dirPin), .brakePin(brakePin), .pwmPin(pwmPin)
);

// ---- dv/hbd_ctrl_tb_top.sv ----
// self-checking bench for the h-bridge drive controller
// assumes the bridge model and bound checker compiled before it
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
	nCompared++; \
	if ((g) !== (e)) begin \
		nFail++; \
		$display("unexpected %s exp %h got %h", nm, e, g); \
	end \
end
module hbd_ctrl_tb_top;
	logic        ref_clk, rst_n, regWr, regRd, irq;
	logic        dirPin, brakePin, pwmPin, warnPull, overAmp;
	logic [3:0]  regAddr;
	logic [31:0] regWdata, regRdata, rv;
	logic [7:0]  tempC;     // die temperature, degrees
	logic [3:0]  sw;        // src1 src2 snk1 snk2
	wire         warnPin_n; // pulled up, model sinks it
	int          shoot, nFail, nCompared, pe, de;
	assign warnPin_n = warnPull ? 1'b0 : 1'b1;
	hbd_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .warnPin_n(warnPin_n),
		.dirPin(dirPin), .brakePin(brakePin), .pwmPin(pwmPin));
	hbd_bridge_model bridge (.ref_clk(ref_clk), .dirPin(dirPin), .brakePin(brakePin),
		.pwmPin(pwmPin), .tempC(tempC), .overAmp(overAmp), .warnPull(warnPull), .sw(sw),
		.shoot(shoot));
	// 50 MHz
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 rv = regRdata;
		`CHK(nm, e, rv)
	endtask
	// counts pwm and direction moves over n cycles
	task automatic edges(input int n);
		logic p;
		logic d;
		pe = 0;
		de = 0;
		p = pwmPin;
		d = dirPin;
		repeat (n) begin
			tick(1);
			pe += int'(pwmPin !== p);
			de += int'(dirPin !== d);
			p = pwmPin;
			d = dirPin;
		end
	endtask
	task automatic summarize();
		if (nFail == 0 && nCompared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// watchdog far beyond the ~9k cycles of the tests
	initial begin
		repeat (40000) @(posedge ref_clk);
		nFail++;
		summarize();
	end
	initial begin
		nFail = 0;
		nCompared = 0;
		{rst_n, regWr, regRd, regAddr, regWdata} = '0;
		tempC = 8'h19;
		overAmp = 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		rc(4'h0, 32'h0, "ctrl");
		rc(4'h1, 32'h0, "duty");
		rc(4'h2, 32'hff, "period");
		rc(4'h5, 32'h0, "mask");
		wr(4'h3, 32'hff);
		rc(4'h3, 32'h10, "status");
		wr(4'h6, 32'hffff_ffff);
		rc(4'h6, 32'h0, "unmapped");
		// sign/magnitude, zero magnitude
		wr(4'h0, 32'h05);
		tick(300);
		`CHK("switches", 4'hc, sw)
		// period of one cycle keeps magnitude always on
		wr(4'h2, 32'h0);
		wr(4'h1, 32'h1);
		tick(300);
		`CHK("switches", 4'h9, sw)
		wr(4'h0, 32'h01);
		tick(300);
		`CHK("switches", 4'h6, sw)
		wr(4'h2, 32'hff);
		wr(4'h1, 32'h80);
		edges(3000);
		`CHK("pwm moves, dir holds", 1'b1, pe > 3 && de == 0)
		// locked anti-phase: duty rides on direction
		wr(4'h0, 32'h03);
		tick(300);
		edges(3000);
		`CHK("dir moves, pwm high", 1'b1, de > 3 && pe == 0 && pwmPin === 1'b1)
		wr(4'h0, 32'h09);
		tick(300);
		`CHK("switches", 4'h3, sw)
		wr(4'h0, 32'h11);
		tick(300);
		`CHK("switches", 4'h0, sw)
		// warning rise then fall through the sticky bits
		wr(4'h5, 32'h1);
		tempC <= 8'h96;
		tick(10);
		`CHK("irq", 1'b1, irq)
		rc(4'h3, 32'h11, "status");
		rc(4'h4, 32'h1, "intst");
		wr(4'h4, 32'h1);
		rc(4'h4, 32'h0, "intst");
		`CHK("irq", 1'b0, irq)
		tempC <= 8'h64;
		tick(10);
		rc(4'h4, 32'h2, "intst");
		`CHK("irq", 1'b0, irq)
		wr(4'h5, 32'h3);
		tick(2);
		`CHK("irq", 1'b1, irq)
		wr(4'h4, 32'h2);
		tick(2);
		`CHK("irq", 1'b0, irq)
		// autostop: a warning drops the drive until disabled
		wr(4'h2, 32'h0);
		wr(4'h1, 32'h1);
		wr(4'h0, 32'h25);
		tick(300);
		`CHK("switches", 4'h9, sw)
		// a current fault drops only the sources, then the bridge retries
		overAmp <= 1'b1;
		tick(1);
		`CHK("cut sources", 4'h1, sw)
		overAmp <= 1'b0;
		tick(20);
		`CHK("retried", 4'h9, sw)
		tempC <= 8'h96;
		tick(300);
		tempC <= 8'h64;
		tick(300);
		`CHK("switches", 4'h0, sw)
		rc(4'h3, 32'h12, "status");
		// second reset in mid-run, both edges on the clock
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		tick(2);
		`CHK("switches", 4'h0, sw)
		`CHK("irq", 1'b0, irq)
		rc(4'h3, 32'h10, "status");
		rc(4'h0, 32'h0, "ctrl");
		`CHK("no shoot-through", 1'b1, shoot == 0)
		summarize();
	end
endmodule
